// >>> synth_cal_pkg.sv
// constants, register table and carrier types for the synthesizer cal bank
// Behaviour
// - bit five picks high or low VCO core
// - current cal field holds result, resets 0x0A
// - coarse tune field holds capacitor setting, resets 0x20
// - cal registers accept host writes for hop restore
// - cal control seven bits, resets 0x0D, bit7 zero
// - 0xBF in production test enables idle temp sensor
// - test zero bit one enables VCO select stage
package synth_cal_pkg;

    // ------------------------------------------------------------------
    // register table
    // ------------------------------------------------------------------
    localparam int REG_COUNT = 8;
    localparam int ADDR_W    = 6;

    localparam int IDX_CURRENT    = 0;
    localparam int IDX_COARSE     = 1;
    localparam int IDX_CONTROL    = 2;
    localparam int IDX_SYNTH_TEST = 3;
    localparam int IDX_PROD_TEST  = 4;
    localparam int IDX_SET_TWO    = 5;
    localparam int IDX_SET_ONE    = 6;
    localparam int IDX_SET_ZERO   = 7;

    localparam logic [5:0] OFF_VCO_CURRENT_CAL   = 6'h24;
    localparam logic [5:0] OFF_VCO_COARSE_CAL    = 6'h25;
    localparam logic [5:0] OFF_SYNTH_CAL_CONTROL = 6'h26;
    localparam logic [5:0] OFF_SYNTH_TEST_REG    = 6'h29;
    localparam logic [5:0] OFF_PRODUCTION_TEST   = 6'h2a;
    localparam logic [5:0] OFF_TEST_SETTINGS_TWO = 6'h2c;
    localparam logic [5:0] OFF_TEST_SETTINGS_ONE = 6'h2d;
    localparam logic [5:0] OFF_TEST_SETTINGS_ZRO = 6'h2e;

    localparam logic [7:0] RST_VCO_CURRENT_CAL   = 8'h0a;
    localparam logic [7:0] RST_VCO_COARSE_CAL    = 8'h20;
    localparam logic [7:0] RST_SYNTH_CAL_CONTROL = 8'h0d;
    localparam logic [7:0] RST_SYNTH_TEST_REG    = 8'h57;
    localparam logic [7:0] RST_PRODUCTION_TEST   = 8'h7f;
    localparam logic [7:0] RST_TEST_SETTINGS_TWO = 8'h00;
    localparam logic [7:0] RST_TEST_SETTINGS_ONE = 8'h21;
    localparam logic [7:0] RST_TEST_SETTINGS_ZRO = 8'h0b;

    // writable bits per register; the rest read zero
    localparam logic [7:0] MASK_SIX_BIT   = 8'h3f;
    localparam logic [7:0] MASK_SEVEN_BIT = 8'h7f;
    localparam logic [7:0] MASK_FULL      = 8'hff;

    localparam logic [5:0] REG_OFFSET [REG_COUNT] = '{
        OFF_VCO_CURRENT_CAL, OFF_VCO_COARSE_CAL, OFF_SYNTH_CAL_CONTROL,
        OFF_SYNTH_TEST_REG, OFF_PRODUCTION_TEST, OFF_TEST_SETTINGS_TWO,
        OFF_TEST_SETTINGS_ONE, OFF_TEST_SETTINGS_ZRO};
    localparam logic [7:0] REG_RESET [REG_COUNT] = '{
        RST_VCO_CURRENT_CAL, RST_VCO_COARSE_CAL, RST_SYNTH_CAL_CONTROL,
        RST_SYNTH_TEST_REG, RST_PRODUCTION_TEST, RST_TEST_SETTINGS_TWO,
        RST_TEST_SETTINGS_ONE, RST_TEST_SETTINGS_ZRO};
    localparam logic [7:0] REG_MASK [REG_COUNT] = '{
        MASK_SIX_BIT, MASK_SIX_BIT, MASK_SEVEN_BIT, MASK_FULL,
        MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL};

    // ------------------------------------------------------------------
    // field positions and special values
    // ------------------------------------------------------------------
    localparam int POS_VCO_HIGH_CORE   = 5;
    localparam int POS_VCO_SELECT_CAL_STAGE_ENABLE  = 1;
    localparam int POS_HDR_READ        = 7;
    localparam int POS_HDR_BURST       = 6;
    localparam logic [7:0] PROD_TEST_TEMP_ON = 8'hbf;
    localparam logic [2:0] LAST_BIT          = 3'h7;

    // ------------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic csn;
        logic sclk;
        logic si;
    } spi_pins_t;

    typedef struct packed {
        logic       valid;
        logic       first;
        logic [7:0] data;
    } spi_byte_t;

    typedef struct packed {
        logic       load_current;
        logic [5:0] current;
        logic       load_coarse;
        logic [5:0] coarse;
    } cal_result_t;

    typedef struct packed {
        logic       vco_high_core_select;
        logic [5:0] vco_current;
        logic [5:0] vco_coarse;
        logic [6:0] cal_control;
        logic [7:0] synth_test;
        logic [7:0] test_two;
        logic [7:0] test_one;
        logic [7:0] test_zero;
        logic       vco_select_cal_stage_enable;
    } synth_cfg_t;

endpackage

// >>> pin_sync.sv
// two-flop synchroniser for the serial port pins
`timescale 1ns/1ps
module pin_sync (
    // clock and reset
    input  wire logic                    mclk,
    input  wire logic                    nrst,
    // raw pins and synchronised copy
    input  wire synth_cal_pkg::spi_pins_t pins,
    output      synth_cal_pkg::spi_pins_t pins_s
);
    import synth_cal_pkg::*;

    spi_pins_t meta;

    // ------------------------------------------------------------------
    // synchroniser
    // ------------------------------------------------------------------
    // chip select idles high so reset leaves the port deselected
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            meta   <= '{csn: 1'b1, sclk: 1'b0, si: 1'b0};
            pins_s <= '{csn: 1'b1, sclk: 1'b0, si: 1'b0};
        end else begin
            meta   <= pins;
            pins_s <= meta;
        end
    end

endmodule

// >>> spi_frame.sv
// serial frame engine: byte assembly on sclk rise, shift out on sclk fall
`timescale 1ns/1ps
module spi_frame (
    // clock and reset
    input  wire logic                     mclk,
    input  wire logic                     nrst,
    // synchronised pins
    input  wire synth_cal_pkg::spi_pins_t pins_s,
    // byte to send in the next byte slot
    input  wire logic [7:0]               tx_byte,
    // received byte, one-cycle valid
    output      synth_cal_pkg::spi_byte_t rx,
    output      logic                     so
);
    import synth_cal_pkg::*;

    logic       sclk_d;
    logic [2:0] bit_cnt;
    logic [6:0] shift_in;
    logic [7:0] shift_out;
    logic       first;

    wire rise = pins_s.sclk & ~sclk_d;
    wire fall = ~pins_s.sclk & sclk_d;
    wire byte_end = rise && (bit_cnt == LAST_BIT);

    // ------------------------------------------------------------------
    // receive side
    // ------------------------------------------------------------------
    // edges come from the second sync stage, never the first
    always_ff @(posedge mclk) begin
        if (!nrst || pins_s.csn) begin
            sclk_d   <= pins_s.sclk;
            bit_cnt  <= 3'h0;
            shift_in <= 7'h00;
            first    <= 1'b1;
            rx       <= '0;
        end else begin
            sclk_d   <= pins_s.sclk;
            rx.valid <= byte_end;
            if (rise) begin
                shift_in <= {shift_in[5:0], pins_s.si};
                bit_cnt  <= bit_cnt + 3'h1;
            end
            if (byte_end) begin
                rx.data <= {shift_in, pins_s.si};
                rx.first <= first;
                first   <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // transmit side
    // ------------------------------------------------------------------
    // a fresh byte is taken on the first fall of each byte slot; the
    // header slot sends zeros since no status byte is kept here
    always_ff @(posedge mclk) begin
        if (!nrst || pins_s.csn) begin
            shift_out <= 8'h00;
            so        <= 1'b0;
        end else if (fall && bit_cnt == 3'h0 && !first) begin
            so        <= tx_byte[7];
            shift_out <= {tx_byte[6:0], 1'b0};
        end else if (fall) begin
            so        <= shift_out[7];
            shift_out <= {shift_out[6:0], 1'b0};
        end
    end

endmodule

// >>> synth_cal_regs.sv
// synthesizer calibration and production test register bank
`timescale 1ns/1ps
module synth_cal_regs (
    // clock and reset
    input  wire logic                       mclk,
    input  wire logic                       nrst,
    // serial register port pins
    input  wire logic                       csn,
    input  wire logic                       sclk,
    input  wire logic                       si,
    output      logic                       so,
    output      logic                       so_oe,
    // calibration engine results
    input  wire synth_cal_pkg::cal_result_t cal,
    // radio state
    input  wire logic                       radio_idle,
    // configuration to the synthesizer
    output      synth_cal_pkg::synth_cfg_t  cfg,
    output      logic                       temp_sensor_on
);
    import synth_cal_pkg::*;

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    spi_pins_t             pins;
    spi_pins_t             pins_s;
    spi_byte_t             rx;
    logic                  so_int;
    logic [7:0]            tx_byte;
    logic [ADDR_W-1:0]     addr;
    logic                  is_read;
    logic                  is_burst;
    logic                  done;
    logic [7:0]            regs      [REG_COUNT];
    logic [7:0]            next_reg  [REG_COUNT];
    logic [7:0]            hw_val    [REG_COUNT];
    logic [7:0]            rd_term   [REG_COUNT];
    logic [7:0]            rd_chain  [REG_COUNT+1];
    logic [REG_COUNT-1:0]  hw_load;

    // ------------------------------------------------------------------
    // pin synchronisation and serial framing
    // ------------------------------------------------------------------
    assign pins = '{csn: csn, sclk: sclk, si: si};

    pin_sync u_sync (
        .mclk   (mclk),
        .nrst   (nrst),
        .pins   (pins),
        .pins_s (pins_s)
    );

    spi_frame u_frame (
        .mclk    (mclk),
        .nrst    (nrst),
        .pins_s  (pins_s),
        .tx_byte (tx_byte),
        .rx      (rx),
        .so      (so_int)
    );

    // ------------------------------------------------------------------
    // header and address decode
    // ------------------------------------------------------------------
    // header byte: bit 7 read, bit 6 burst, bits 5:0 register address
    wire hdr_valid  = rx.valid && rx.first;
    wire data_valid = rx.valid && !rx.first && !done;
    wire wr_en      = data_valid && !is_read;
    wire [7:0] wr_data = rx.data;

    // address of the byte slot that follows the current one
    wire [ADDR_W-1:0] addr_inc = addr + 6'h01;
    wire [ADDR_W-1:0] rd_addr  = hdr_valid ? rx.data[ADDR_W-1:0] :
                                 is_burst  ? addr_inc : addr;

    // a single access stops after one data byte; later bytes are dropped
    wire next_done = hdr_valid ? 1'b0 : (data_valid && !is_burst) | done;

    // transaction state follows chip select; deselect ends it
    always_ff @(posedge mclk) begin
        if (!nrst || pins_s.csn) begin
            addr     <= 6'h00;
            is_read  <= 1'b0;
            is_burst <= 1'b0;
            done     <= 1'b0;
        end else begin
            done <= next_done;
            if (hdr_valid) begin
                addr     <= rx.data[ADDR_W-1:0];
                is_read  <= rx.data[POS_HDR_READ];
                is_burst <= rx.data[POS_HDR_BURST];
            end else if (data_valid && is_burst) begin
                addr     <= addr_inc;
            end
        end
    end

    // ------------------------------------------------------------------
    // calibration engine updates
    // ------------------------------------------------------------------
    // the engine writes its results into the same storage the host
    // reads back, which is what makes save and restore possible
    assign hw_load = (REG_COUNT'(cal.load_current) << IDX_CURRENT) |
                     (REG_COUNT'(cal.load_coarse)  << IDX_COARSE);

    // ------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------
    assign rd_chain[0] = 8'h00;

    genvar i;
    generate
        for (i = 0; i < REG_COUNT; i = i + 1) begin : g_reg
            wire host_hit = wr_en && (addr == REG_OFFSET[i]);

            // engine result wins over a host write landing in the
            // same cycle, so a finished calibration is never lost
            assign hw_val[i] = (i == IDX_CURRENT) ? {2'b00, cal.current} :
                               (i == IDX_COARSE)  ? {2'b00, cal.coarse}  :
                               8'h00;

            // host writes steer the synthesizer directly
            // unused bits masked on write
            assign next_reg[i] = hw_load[i] ? (hw_val[i] & REG_MASK[i]) :
                                 host_hit   ? (wr_data & REG_MASK[i])   :
                                 regs[i];

            // reset values per register
            always_ff @(posedge mclk) begin
                if (!nrst) begin
                    regs[i] <= REG_RESET[i];
                end else begin
                    regs[i] <= next_reg[i];
                end
            end

            // unmapped addresses fall through as zero
            assign rd_term[i]    = (rd_addr == REG_OFFSET[i]) ?
                                   regs[i] : 8'h00;
            assign rd_chain[i+1] = rd_chain[i] | rd_term[i];
        end
    endgenerate

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    // read data is staged one byte slot ahead so it is ready well
    // before the first falling sclk edge of the slot
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            tx_byte <= 8'h00;
        end else if (rx.valid) begin
            tx_byte <= rd_chain[REG_COUNT];
        end
    end

    // ------------------------------------------------------------------
    // serial output driver
    // ------------------------------------------------------------------
    // the output is only driven while the port is selected
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            so    <= 1'b0;
            so_oe <= 1'b0;
        end else begin
            so    <= so_int;
            so_oe <= ~pins_s.csn;
        end
    end

    // ------------------------------------------------------------------
    // configuration outputs
    // ------------------------------------------------------------------
    // decoded fields, registered again so every output is a flop
    wire [7:0] cur_reg  = regs[IDX_CURRENT];
    wire [7:0] set_zero = regs[IDX_SET_ZERO];
    wire high_core      = cur_reg[POS_VCO_HIGH_CORE];
    wire sel_cal_enable = set_zero[POS_VCO_SELECT_CAL_STAGE_ENABLE];

    // the sensor is exposed only in idle; leaving idle with 0xbf still
    // loaded drops it here, but the host must still restore 0x7f
    wire next_temp_on = (regs[IDX_PROD_TEST] == PROD_TEST_TEMP_ON) &&
                        radio_idle;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cfg            <= '0;
            temp_sensor_on <= 1'b0;
        end else begin
            cfg.vco_high_core_select        <= high_core;
            cfg.vco_current                 <= cur_reg[5:0];
            cfg.vco_coarse                  <= regs[IDX_COARSE][5:0];
            cfg.cal_control                 <= regs[IDX_CONTROL][6:0];
            cfg.synth_test                  <= regs[IDX_SYNTH_TEST];
            cfg.test_two                    <= regs[IDX_SET_TWO];
            cfg.test_one                    <= regs[IDX_SET_ONE];
            cfg.test_zero                   <= set_zero;
            cfg.vco_select_cal_stage_enable <= sel_cal_enable;
            temp_sensor_on                  <= next_temp_on;
        end
    end

endmodule

// >>> synth_cal_regs_assertions.sv
// concurrent checks on the synthesizer calibration bank ports
`timescale 1ns/1ps
module synth_cal_regs_assertions (
    // clock and reset
    input wire logic                       mclk,
    input wire logic                       nrst,
    // serial port
    input wire logic                       csn,
    input wire logic                       so_oe,
    // calibration engine and radio state
    input wire synth_cal_pkg::cal_result_t cal,
    input wire logic                       radio_idle,
    // outputs to the synthesizer
    input wire synth_cal_pkg::synth_cfg_t  cfg,
    input wire logic                       temp_sensor_on
);
    import synth_cal_pkg::*;

    // single clock domain, so one clocking and one disable for all
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    // ------------------------------------------------------------
    // port relations
    // ------------------------------------------------------------
    a_high_core_map:
        assert property (cfg.vco_high_core_select == cfg.vco_current[5])
        else $error("high core select differs from current bit five");
    a_current_load:
        assert property (cal.load_current |->
            ##2 cfg.vco_current == $past(cal.current, 2))
        else $error("current cal load not seen on cfg");
    a_coarse_load:
        assert property (cal.load_coarse |->
            ##2 cfg.vco_coarse == $past(cal.coarse, 2))
        else $error("coarse cal load not seen on cfg");
    a_reset_cal:
        assert property ($rose(nrst) |=> cfg.vco_current == 6'h0a &&
            cfg.vco_coarse == 6'h20 && cfg.cal_control == 7'h0d)
        else $error("cal fields wrong after reset");
    a_reset_test:
        assert property ($rose(nrst) |=> cfg.synth_test == 8'h57 &&
            cfg.vco_select_cal_stage_enable && !cfg.vco_high_core_select)
        else $error("test fields wrong after reset");
    a_sel_cal_map:
        assert property (cfg.vco_select_cal_stage_enable == cfg.test_zero[1])
        else $error("select cal enable differs from test zero bit one");
    a_temp_idle:
        assert property (!radio_idle |=> !temp_sensor_on)
        else $error("temperature sensor on outside idle");
    a_temp_rise:
        assert property ($rose(temp_sensor_on) |-> $past(radio_idle))
        else $error("temperature sensor rose without idle");
    a_idle_stable:
        assert property (csn [*8] |=> $stable({cfg.cal_control,
            cfg.synth_test, cfg.test_two, cfg.test_one, cfg.test_zero}))
        else $error("config changed with no frame");
    a_oe_idle:
        assert property (csn [*4] |-> !so_oe)
        else $error("so driven while deselected");
endmodule

bind synth_cal_regs synth_cal_regs_assertions chk_u (
    .mclk(mclk), .nrst(nrst), .csn(csn), .so_oe(so_oe), .cal(cal),
    .radio_idle(radio_idle), .cfg(cfg), .temp_sensor_on(temp_sensor_on));

// >>> spi_host_model.sv
// host side of the serial register port, mode 0, msb first
`timescale 1ns/1ps
module spi_host_model (
    // clock
    input  wire logic mclk,
    // serial port pins
    output      logic csn,
    output      logic sclk,
    output      logic si,
    input  wire logic so,
    input  wire logic so_oe
);
    logic last_so;
    logic so_line;

    // no pull on so: a released line shows the inverse of its last level
    always @(posedge mclk) if (so_oe) last_so <= so;
    assign so_line = so_oe ? so : ~last_so;

    initial begin
        csn = 1'b1;
        sclk = 1'b0;
        si = 1'b0;
        last_so = 1'b0;
    end

    // ------------------------------------------------------------
    // frame: hp mclk per sclk half, last byte cut to nb bits
    // ------------------------------------------------------------
    // called just after an mclk rise; every pin moves only there
    task automatic frame(input logic [7:0] tx [$], input int hp,
                         input int nb, output logic [7:0] rx [$]);
        logic [7:0] b;
        int n;
        rx = {};
        csn = 1'b0;
        foreach (tx[k]) begin
            b = 8'h00;
            n = (k == tx.size() - 1) ? nb : 8;
            for (int i = 7; i >= 8 - n; i--) begin
                si = tx[k][i];
                repeat (hp) @(posedge mclk);
                #1;
                b[i] = so_line;
                sclk = 1'b1;
                repeat (hp) @(posedge mclk);
                #1;
                sclk = 1'b0;
            end
            rx.push_back(b);
        end
        repeat (hp) @(posedge mclk);
        #1;
        csn = 1'b1;
        si = ~si;
        repeat (4) @(posedge mclk);
        #1;
    endtask
endmodule

// >>> test_synth_cal_regs.sv
// self-checking bench for the synthesizer calibration register bank
`timescale 1ns/1ps
module test_synth_cal_regs;
    import synth_cal_pkg::*;
    logic        mclk, nrst, csn, sclk, si, so, so_oe;
    logic        radio_idle, temp_sensor_on;
    cal_result_t cal;
    synth_cfg_t  cfg;
    int          n_mismatch, checks_done;
    logic [7:0]  mdl [64];
    logic [7:0]  tq [$];
    logic [7:0]  rq [$];
    logic [7:0]  d;
    logic [5:0]  wa [7] = '{6'h24, 6'h25, 6'h26, 6'h27, 6'h2c, 6'h2d, 6'h2e};

    synth_cal_regs dut_u (.mclk(mclk), .nrst(nrst), .csn(csn), .sclk(sclk),
        .si(si), .so(so), .so_oe(so_oe), .cal(cal), .radio_idle(radio_idle),
        .cfg(cfg), .temp_sensor_on(temp_sensor_on));
    spi_host_model host_u (.mclk(mclk), .csn(csn), .sclk(sclk), .si(si),
        .so(so), .so_oe(so_oe));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // ------------------------------------------------------------
    // reference image and checks
    // ------------------------------------------------------------
    task automatic init_mdl;
        foreach (mdl[a]) mdl[a] = 8'h00;
        for (int k = 0; k < REG_COUNT; k++) mdl[REG_OFFSET[k]] = REG_RESET[k];
    endtask
    // unmapped places stay zero, unused bits are masked off
    task automatic mwr(input logic [5:0] a, input logic [7:0] v);
        for (int k = 0; k < REG_COUNT; k++)
            if (REG_OFFSET[k] == a) mdl[a] = v & REG_MASK[k];
    endtask
    task automatic chk_rd(input string nm, input logic [7:0] e,
                          input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_out(input string nm, input logic [63:0] e,
                           input logic [63:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_cfg;
        synth_cfg_t e;
        e = '{mdl[6'h24][5], mdl[6'h24][5:0], mdl[6'h25][5:0],
              mdl[6'h26][6:0], mdl[6'h29], mdl[6'h2c], mdl[6'h2d],
              mdl[6'h2e], mdl[6'h2e][1]};
        chk_out("cfg", 64'(e), 64'(cfg));
    endtask
    // one frame; tq holds write data, or filler for a read
    task automatic access(input bit rd, input bit bst, input logic [5:0] a,
                          input int hp);
        logic [7:0] tx [$];
        logic [5:0] p;
        tx = '{{rd, bst, a}};
        p = a;
        foreach (tq[k]) begin
            tx.push_back(tq[k]);
            if (!rd && (bst || k == 0)) mwr(p, tq[k]);
            if (bst) p++;
        end
        host_u.frame(tx, hp, 8, rq);
        chk_rd("header slot", 8'h00, rq[0]);
        foreach (tq[k])
            if (rd && (bst || k == 0))
                chk_rd("read", mdl[6'(a + k)], rq[k + 1]);
    endtask
    task automatic complete_run;
        if (n_mismatch == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // watchdog sized well above the roughly 23k cycles of the sequence
    initial begin
        repeat (80000) @(posedge mclk);
        n_mismatch++;
        complete_run();
    end

    initial begin
        nrst = 1'b0;
        cal = '0;
        radio_idle = 1'b0;
        n_mismatch = 0;
        checks_done = 0;
        d = 8'($urandom(72884));
        for (int r = 0; r < 2; r++) begin
            nrst = 1'b0;
            init_mdl();
            repeat (12) @(posedge mclk);
            #1 nrst = 1'b1;
            repeat (4) @(posedge mclk);
            #1;
            chk_cfg();
            tq = '{};
            repeat (11) tq.push_back(8'h00);
            access(1, 1, 6'h24, 6);
            // dirty the cal fields so the second reset must restore them
            tq = '{8'hff, 8'hff, 8'hff};
            access(0, 1, 6'h24, 6);
        end
        // random and all-ones writes, two host speeds; 0x29 never written
        for (int r = 0; r < 6; r++) begin
            foreach (wa[i]) begin
                tq = '{8'($urandom)};
                if (r == 0) tq[0] = 8'hff;
                access(0, 0, wa[i], 5 + (r % 2) * 4);
                tq = '{8'h00};
                access(1, 0, wa[i], 5);
            end
            chk_cfg();
        end
        // hop restore of saved results by one burst
        tq = '{8'($urandom), 8'($urandom), 8'($urandom)};
        access(0, 1, 6'h24, 8);
        access(1, 1, 6'h24, 8);
        chk_cfg();
        // non-burst write with a trailing byte that must be ignored
        tq = '{8'($urandom), 8'($urandom)};
        access(0, 0, 6'h25, 6);
        access(1, 1, 6'h25, 6);
        // calibration engine loads both results in one cycle
        d = 8'($urandom);
        cal = '{1'b1, d[5:0], 1'b1, ~d[5:0]};
        mdl[6'h24] = {2'b00, d[5:0]};
        mdl[6'h25] = {2'b00, ~d[5:0]};
        @(posedge mclk);
        #1 cal.load_current = 1'b0;
        cal.load_coarse = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        chk_cfg();
        access(1, 1, 6'h24, 5);
        // sensor in idle, default restored before idle ends
        radio_idle = 1'b1;
        tq = '{8'hbf};
        access(0, 0, 6'h2a, 5);
        chk_out("temp on", 64'(1'b1), 64'(temp_sensor_on));
        tq = '{8'h7f};
        access(0, 0, 6'h2a, 5);
        chk_out("temp off", 64'(1'b0), 64'(temp_sensor_on));
        radio_idle = 1'b0;
        // csn raised mid-byte: the partial byte is discarded
        tq = '{8'h2d, 8'($urandom)};
        host_u.frame(tq, 6, 4, rq);
        tq = '{8'h00};
        access(1, 0, 6'h2d, 6);
        complete_run();
    end
endmodule
